/* logic/hot_swap_defs.vh */
`ifndef HOT_SWAP_DEFS_VH
`define HOT_SWAP_DEFS_VH

// ****************************************************************
// Register offsets on the management port
// ****************************************************************
`define ADDR_HV_CHANNEL_LIMITS        8'h03
`define ADDR_HV_CHANNEL_TIMING_ENABLE 8'h04
`define ADDR_LATCHED_CHANNEL_FLAGS    8'h07
`define ADDR_LATCHED_OVERCURRENT      8'h08
`define ADDR_LIVE_FET_STATUS          8'h09

// ****************************************************************
// Reset values and unmapped read value
// ****************************************************************
`define RESET_HV_CHANNEL_LIMITS        8'hBF
`define RESET_HV_CHANNEL_TIMING_ENABLE 8'h01
`define READ_UNMAPPED                  8'h00

// ****************************************************************
// Field positions, limits register
// ****************************************************************
`define LIMIT_SCALE_LSB     0
`define LIMIT_SCALE_MSB     3
`define GOOD_THRESH_LSB     4
`define GOOD_THRESH_MSB     5
`define ORING_POS_OFFSET    6
`define ORING_PERMIT        7

// ****************************************************************
// Field positions, timing and enable register
// ****************************************************************
`define FAULT_CODE_LSB      0
`define FAULT_CODE_MSB      4
`define MASTER_ENABLE       5
`define REARM_LOCKOUT       6
`define DISCHARGE_CONNECT   7

// ****************************************************************
// Field positions, latched and live status registers
// ****************************************************************
`define HV_PG_LOSS_BIT      4
`define HV_TIMEOUT_BIT      5
`define LV_PG_LOSS_BIT      6
`define LV_TIMEOUT_BIT      7
`define HV_OVERCURRENT_BIT  4
`define HV_FASTTRIP_BIT     5
`define LV_OVERCURRENT_BIT  6
`define LV_FASTTRIP_BIT     7
`define BLOCK_GATE_BIT      3
`define SERIES_GATE_BIT     4
`define LV_DIRECTION_BIT    5
`define LV_GATE_BIT         7

// ****************************************************************
// Timing
// ****************************************************************
`define CLOCK_PERIOD_PS     5000
`define FAULT_LSB_PS        450000000
`define FAULT_LSB_CYCLES    (`FAULT_LSB_PS / `CLOCK_PERIOD_PS)
`define UNIT_COUNT_WIDTH    17

`endif

/* logic/fault_timer.v */
`timescale 1ns/1ps
`include "hot_swap_defs.vh"

// Counts fault-time units while the channel sits in current limit
module fault_timer #(
    parameter UNIT_CYCLES = `FAULT_LSB_CYCLES
) (
    // Clock and reset
    input  wire       clock,
    input  wire       resetn,
    // Control
    input  wire       run,
    input  wire [4:0] code,
    // Result
    output reg        expired
);

    reg  [`UNIT_COUNT_WIDTH-1:0] unitCount_reg;
    reg  [4:0]                   unitsDone_reg;
    wire                         unitTick;
    wire [4:0]                   unitsPlusOne;

    // ****************************************************************
    // Unit divider
    // ****************************************************************
    // Restarted whenever the limit ends, so every run starts a full unit
    assign unitTick     = run && (unitCount_reg == UNIT_CYCLES[`UNIT_COUNT_WIDTH-1:0] - 1'b1);
    assign unitsPlusOne = unitsDone_reg + 5'h1;

    // Divider and unit counter
    always @(posedge clock) begin
        if (!resetn || !run) begin
            unitCount_reg <= {`UNIT_COUNT_WIDTH{1'b0}};
            unitsDone_reg <= 5'h0;
            expired       <= 1'b0;
        end else if (unitTick) begin
            unitCount_reg <= {`UNIT_COUNT_WIDTH{1'b0}};
            // Hold one below the code so a stuck limit does not wrap around
            if (unitsPlusOne == code) begin
                expired       <= 1'b1;
                unitsDone_reg <= unitsDone_reg;
            end else begin
                expired       <= 1'b0;
                unitsDone_reg <= unitsPlusOne;
            end
        end else begin
            unitCount_reg <= unitCount_reg + 1'b1;
            expired       <= 1'b0;
        end
    end

endmodule // fault_timer

/* logic/hot_swap_config_status_regs.v */
// Behaviour
// - Set the high-voltage power-good-loss flag on an output fall below threshold.
// - Set the high-voltage fault flag when its fault timer expires.
// - Set the low-voltage power-good-loss flag on an output fall below threshold.
// - Set the low-voltage fault flag when its fault timer expires.
// - Reading either latched flag register clears its flags.
// - Set the high-voltage overcurrent flag on entering current limit.
// - Set the high-voltage fast-trip flag when its fast-trip threshold is exceeded.
// - Set the low-voltage overcurrent flag on entering current limit.
// - Set the low-voltage fast-trip flag when its fast-trip threshold is exceeded.
// - Blocking-gate status bit reads high while that gate is commanded high.
// - FET status bits are live and unlatched; all but the blocking-gate bit are active-low conditions.
// - A four-bit field scales high-voltage current limit and fast trip.
// - A two-bit field sets the high-voltage power-good threshold.
// - One bit moves the ORing turn-off threshold to a positive offset.
// - With the ORing permit bit clear the blocking gate stays low.
// - A five-bit code sets fault time in 0.45 ms steps.
// - Master enable clear pulls both series and blocking gates low.
// - With re-arm set, turn-on waits until the output bleeds down.
// - Discharge bit clear disconnects the bleed-down resistor.
`timescale 1ns/1ps
`include "hot_swap_defs.vh"

module hot_swap_config_status_regs #(
    parameter UNIT_CYCLES = `FAULT_LSB_CYCLES
) (
    // Clock and reset
    input  wire       clock,
    input  wire       resetn,
    // Register port from the serial bus engine
    input  wire [7:0] regAddress,
    input  wire       regWrite,
    input  wire [7:0] regWriteData,
    input  wire       regRead,
    output reg  [7:0] regReadData,
    output reg        regReadValid,
    // Analog comparators and the low-voltage channel, asynchronous
    input  wire       hvAboveGood,
    input  wire       lvAboveGood,
    input  wire       hvInLimit,
    input  wire       lvInLimit,
    input  wire       hvFastTrip,
    input  wire       lvFastTrip,
    input  wire       hvOutBelowBleed,
    input  wire       lvTimeout,
    input  wire       hvSeriesEnhancedN,
    input  wire       lvDirectionN,
    input  wire       lvGateOnN,
    // Gate and analog trim controls
    output reg        hvSeriesGate,
    output reg        oringBlockGate,
    output reg  [3:0] hvLimitScale,
    output reg  [1:0] hvGoodThresholdSel,
    output reg        hvOringPositiveOffset,
    output reg        hvDischargeConnect
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    localparam NUM_SYNC = 11;

    localparam IDX_HV_GOOD   = 0;
    localparam IDX_LV_GOOD   = 1;
    localparam IDX_HV_LIMIT  = 2;
    localparam IDX_LV_LIMIT  = 3;
    localparam IDX_HV_FAST   = 4;
    localparam IDX_LV_FAST   = 5;
    localparam IDX_HV_BLEED  = 6;
    localparam IDX_LV_TOUT   = 7;
    localparam IDX_SERIES_N  = 8;
    localparam IDX_LV_DIR_N  = 9;
    localparam IDX_LV_GATE_N = 10;

    wire [NUM_SYNC-1:0] rawIn;
    reg  [NUM_SYNC-1:0] syncFirst_reg;
    reg  [NUM_SYNC-1:0] syncLevel_reg;
    reg  [NUM_SYNC-1:0] syncPrev_reg;

    assign rawIn = {lvGateOnN, lvDirectionN, hvSeriesEnhancedN, lvTimeout,
                    hvOutBelowBleed, lvFastTrip, hvFastTrip, lvInLimit,
                    hvInLimit, lvAboveGood, hvAboveGood};

    // Two flops per input, then one more for edge detection
    genvar g;
    generate
        for (g = 0; g < NUM_SYNC; g = g + 1) begin : gen_sync
            always @(posedge clock) begin
                if (!resetn) begin
                    syncFirst_reg[g] <= 1'b0;
                    syncLevel_reg[g] <= 1'b0;
                    syncPrev_reg[g]  <= 1'b0;
                end else begin
                    syncFirst_reg[g] <= rawIn[g];
                    syncLevel_reg[g] <= syncFirst_reg[g];
                    syncPrev_reg[g]  <= syncLevel_reg[g];
                end
            end
        end
    endgenerate

    wire [NUM_SYNC-1:0] riseEdge;
    wire [NUM_SYNC-1:0] fallEdge;

    assign riseEdge = syncLevel_reg & ~syncPrev_reg;
    assign fallEdge = ~syncLevel_reg & syncPrev_reg;

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    reg  [7:0] limits_reg;
    reg  [7:0] timingEnable_reg;
    wire       writeLimits;
    wire       writeTiming;

    assign writeLimits = regWrite && (regAddress == `ADDR_HV_CHANNEL_LIMITS);
    assign writeTiming = regWrite && (regAddress == `ADDR_HV_CHANNEL_TIMING_ENABLE);

    // Writes to read-only or unmapped offsets are dropped
    always @(posedge clock) begin
        if (!resetn) begin
            limits_reg       <= `RESET_HV_CHANNEL_LIMITS;
            timingEnable_reg <= `RESET_HV_CHANNEL_TIMING_ENABLE;
        end else begin
            if (writeLimits) begin
                limits_reg <= regWriteData;
            end
            if (writeTiming) begin
                timingEnable_reg <= regWriteData;
            end
        end
    end

    wire [4:0] faultCode;
    wire       masterEnable;
    wire       rearmLockout;
    wire       oringPermit;

    assign faultCode    = timingEnable_reg[`FAULT_CODE_MSB:`FAULT_CODE_LSB];
    assign masterEnable = timingEnable_reg[`MASTER_ENABLE];
    assign rearmLockout = timingEnable_reg[`REARM_LOCKOUT];
    assign oringPermit  = limits_reg[`ORING_PERMIT];

    // Trim outputs follow the fields directly, one flop behind
    always @(posedge clock) begin
        if (!resetn) begin
            hvLimitScale          <= 4'hF;
            hvGoodThresholdSel    <= 2'h3;
            hvOringPositiveOffset <= 1'b0;
            hvDischargeConnect    <= 1'b0;
        end else begin
            hvLimitScale          <= limits_reg[`LIMIT_SCALE_MSB:`LIMIT_SCALE_LSB];
            hvGoodThresholdSel    <= limits_reg[`GOOD_THRESH_MSB:`GOOD_THRESH_LSB];
            hvOringPositiveOffset <= limits_reg[`ORING_POS_OFFSET];
            hvDischargeConnect    <= timingEnable_reg[`DISCHARGE_CONNECT];
        end
    end

    // ****************************************************************
    // Fault timer
    // ****************************************************************
    wire hvTimerExpired;

    fault_timer #(
        .UNIT_CYCLES (UNIT_CYCLES)
    ) u_hv_fault_timer (
        .clock   (clock),
        .resetn  (resetn),
        .run     (syncLevel_reg[IDX_HV_LIMIT] && hvSeriesGate),
        .code    (faultCode),
        .expired (hvTimerExpired)
    );

    // ****************************************************************
    // High-voltage channel sequencer
    // ****************************************************************
    localparam ST_OFF     = 4'b0001;
    localparam ST_WAIT    = 4'b0010;
    localparam ST_ON      = 4'b0100;
    localparam ST_TRIPPED = 4'b1000;

    reg [3:0] chanState_reg;
    reg [3:0] chanState_next;

    // Next state; a trip holds until software cycles the master enable
    always @* begin
        chanState_next = chanState_reg;
        case (chanState_reg)
            ST_OFF: begin
                if (masterEnable) begin
                    if (rearmLockout && !syncLevel_reg[IDX_HV_BLEED]) begin
                        chanState_next = ST_WAIT;
                    end else begin
                        chanState_next = ST_ON;
                    end
                end
            end
            ST_WAIT: begin
                if (!masterEnable) begin
                    chanState_next = ST_OFF;
                end else if (syncLevel_reg[IDX_HV_BLEED]) begin
                    chanState_next = ST_ON;
                end
            end
            ST_ON: begin
                if (!masterEnable) begin
                    chanState_next = ST_OFF;
                end else if (hvTimerExpired) begin
                    chanState_next = ST_TRIPPED;
                end
            end
            ST_TRIPPED: begin
                if (!masterEnable) begin
                    chanState_next = ST_OFF;
                end
            end
            default: begin
                chanState_next = ST_OFF;
            end
        endcase
    end

    // State and gate drive
    always @(posedge clock) begin
        if (!resetn) begin
            chanState_reg  <= ST_OFF;
            hvSeriesGate   <= 1'b0;
            oringBlockGate <= 1'b0;
        end else begin
            chanState_reg  <= chanState_next;
            hvSeriesGate   <= (chanState_next == ST_ON);
            oringBlockGate <= (chanState_next == ST_ON) && oringPermit;
        end
    end

    // ****************************************************************
    // Latched flag registers
    // ****************************************************************
    reg  [7:0] chanFlags_reg;
    reg  [7:0] ocFlags_reg;
    wire [7:0] chanSet;
    wire [7:0] ocSet;
    wire       readChan;
    wire       readOc;

    assign readChan = regRead && (regAddress == `ADDR_LATCHED_CHANNEL_FLAGS);
    assign readOc   = regRead && (regAddress == `ADDR_LATCHED_OVERCURRENT);

    assign chanSet = ({7'h00, fallEdge[IDX_HV_GOOD]} << `HV_PG_LOSS_BIT)
                   | ({7'h00, hvTimerExpired}        << `HV_TIMEOUT_BIT)
                   | ({7'h00, fallEdge[IDX_LV_GOOD]} << `LV_PG_LOSS_BIT)
                   | ({7'h00, riseEdge[IDX_LV_TOUT]} << `LV_TIMEOUT_BIT);

    assign ocSet = ({7'h00, riseEdge[IDX_HV_LIMIT]} << `HV_OVERCURRENT_BIT)
                 | ({7'h00, riseEdge[IDX_HV_FAST]}  << `HV_FASTTRIP_BIT)
                 | ({7'h00, riseEdge[IDX_LV_LIMIT]} << `LV_OVERCURRENT_BIT)
                 | ({7'h00, riseEdge[IDX_LV_FAST]}  << `LV_FASTTRIP_BIT);

    // An event in the read cycle survives: the set wins over the clear
    always @(posedge clock) begin
        if (!resetn) begin
            chanFlags_reg <= 8'h00;
            ocFlags_reg   <= 8'h00;
        end else begin
            chanFlags_reg <= (readChan ? 8'h00 : chanFlags_reg) | chanSet;
            ocFlags_reg   <= (readOc ? 8'h00 : ocFlags_reg) | ocSet;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    reg [7:0] liveStatus;
    reg [7:0] readMux;

    always @* begin
        liveStatus                    = 8'h00;
        liveStatus[`BLOCK_GATE_BIT]   = oringBlockGate;
        liveStatus[`SERIES_GATE_BIT]  = syncLevel_reg[IDX_SERIES_N];
        liveStatus[`LV_DIRECTION_BIT] = syncLevel_reg[IDX_LV_DIR_N];
        liveStatus[`LV_GATE_BIT]      = syncLevel_reg[IDX_LV_GATE_N];
    end

    // Unmapped offsets read as zero rather than stalling the bus engine
    always @* begin
        case (regAddress)
            `ADDR_HV_CHANNEL_LIMITS:        readMux = limits_reg;
            `ADDR_HV_CHANNEL_TIMING_ENABLE: readMux = timingEnable_reg;
            `ADDR_LATCHED_CHANNEL_FLAGS:    readMux = chanFlags_reg;
            `ADDR_LATCHED_OVERCURRENT:      readMux = ocFlags_reg;
            `ADDR_LIVE_FET_STATUS:          readMux = liveStatus;
            default:                        readMux = `READ_UNMAPPED;
        endcase
    end

    // Data captured with the pre-clear flag values
    always @(posedge clock) begin
        if (!resetn) begin
            regReadData  <= 8'h00;
            regReadValid <= 1'b0;
        end else begin
            regReadValid <= regRead;
            if (regRead) begin
                regReadData <= readMux;
            end
        end
    end

endmodule // hot_swap_config_status_regs

/* sim/mgmt_host_model.sv */
`timescale 1ns/1ps

// Serial management host stand-in: one strobe per byte, one idle cycle between
module mgmt_host_model (
    // Clock
    input  wire       clock,
    // Register port
    output reg  [7:0] regAddress,
    output reg        regWrite,
    output reg  [7:0] regWriteData,
    output reg        regRead,
    input  wire [7:0] regReadData,
    input  wire       regReadValid
);
    // Idle bus from time zero
    initial begin
        regAddress = 8'h00;
        regWrite = 1'b0;
        regWriteData = 8'h00;
        regRead = 1'b0;
    end

    // Fault code zero never sent
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a == 8'h04 && d[4:0] == 5'h00)
            d[0] = 1'b1;
        @(posedge clock);
        #1;
        regAddress = a;
        regWriteData = d;
        regWrite = 1'b1;
        @(posedge clock);
        #1;
        regWrite = 1'b0;
        regWriteData = ~d;
    endtask

    // Read one byte; ok stays low if no answer within the bound
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge clock);
        #1;
        regAddress = a;
        regRead = 1'b1;
        @(posedge clock);
        #1;
        regRead = 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (regReadValid === 1'b1) begin
                ok = 1'b1;
                d = regReadData;
            end else
                @(posedge clock) #1;
        end
    endtask
endmodule // mgmt_host_model

/* sim/hot_swap_monitor.sv */
`timescale 1ns/1ps

// Watches register port and trim outputs of the config/status bank
module hot_swap_monitor #(
    parameter UNIT_CYCLES = 4
) (
    // Clock and reset
    input wire       clock,
    input wire       resetn,
    // Register port
    input wire [7:0] regAddress,
    input wire       regWrite,
    input wire [7:0] regWriteData,
    input wire       regRead,
    input wire [7:0] regReadData,
    input wire       regReadValid,
    // Gates and trims
    input wire       hvSeriesGate,
    input wire       oringBlockGate,
    input wire [3:0] hvLimitScale,
    input wire [1:0] hvGoodThresholdSel,
    input wire       hvOringPositiveOffset,
    input wire       hvDischargeConnect
);
    default clocking mclk @(posedge clock); endclocking
    default disable iff (!resetn);

    // Writes land in the register one edge later, on the trims one more
    property p_scale;
        regWrite && regAddress == 8'h03 |-> ##2 hvLimitScale == $past(regWriteData[3:0], 2);
    endproperty
    a_scale: assert property (p_scale)
        else $error("limit scale does not follow write");
    property p_good;
        regWrite && regAddress == 8'h03 |-> ##2 hvGoodThresholdSel == $past(regWriteData[5:4], 2);
    endproperty
    a_good: assert property (p_good)
        else $error("good threshold select does not follow write");
    property p_offset;
        regWrite && regAddress == 8'h03 |-> ##2 hvOringPositiveOffset == $past(regWriteData[6], 2);
    endproperty
    a_offset: assert property (p_offset)
        else $error("oring offset does not follow write");
    property p_discharge;
        regWrite && regAddress == 8'h04 |-> ##2 hvDischargeConnect == $past(regWriteData[7], 2);
    endproperty
    a_discharge: assert property (p_discharge)
        else $error("discharge connect does not follow write");
    property p_permit;
        regWrite && regAddress == 8'h03 && !regWriteData[7] |-> ##2 !oringBlockGate;
    endproperty
    a_permit: assert property (p_permit)
        else $error("blocking gate high with permit clear");
    property p_disable;
        regWrite && regAddress == 8'h04 && !regWriteData[5] |-> ##2 !hvSeriesGate && !oringBlockGate;
    endproperty
    a_disable: assert property (p_disable)
        else $error("gates not low after master disable");
    property p_answer;
        regRead |=> regReadValid ##1 !regReadValid || $past(regRead);
    endproperty
    a_answer: assert property (p_answer)
        else $error("read answer missing or too long");
    property p_noanswer;
        !regRead |=> !regReadValid;
    endproperty
    a_noanswer: assert property (p_noanswer)
        else $error("read answer without request");
    property p_spare7;
        regRead && regAddress == 8'h07 |=> regReadData[3:0] == 4'h0;
    endproperty
    a_spare7: assert property (p_spare7)
        else $error("spare flag bits read nonzero");
    property p_spare9;
        regRead && regAddress == 8'h09 |=> regReadData[2:0] == 3'h0 && !regReadData[6];
    endproperty
    a_spare9: assert property (p_spare9)
        else $error("spare status bits read nonzero");
    property p_blockbit;
        regRead && regAddress == 8'h09 |=> regReadData[3] == $past(oringBlockGate);
    endproperty
    a_blockbit: assert property (p_blockbit)
        else $error("block gate status bit differs from gate");

    // Main scenarios reached
    c_enable: cover property (regWrite && regAddress == 8'h04 && regWriteData[5]);
    c_gateOn: cover property ($rose(hvSeriesGate));
    c_flags: cover property (regReadValid && regReadData != 8'h00);
endmodule // hot_swap_monitor

bind hot_swap_config_status_regs hot_swap_monitor #(.UNIT_CYCLES(UNIT_CYCLES)) mon_inst (
    .clock(clock), .resetn(resetn), .regAddress(regAddress), .regWrite(regWrite),
    .regWriteData(regWriteData), .regRead(regRead), .regReadData(regReadData),
    .regReadValid(regReadValid), .hvSeriesGate(hvSeriesGate),
    .oringBlockGate(oringBlockGate), .hvLimitScale(hvLimitScale),
    .hvGoodThresholdSel(hvGoodThresholdSel),
    .hvOringPositiveOffset(hvOringPositiveOffset), .hvDischargeConnect(hvDischargeConnect));

/* sim/tb_top.sv */
`timescale 1ns/1ps

module tb_top;
    logic clock = 1'b0, resetn = 1'b0;
    logic hvAboveGood = 1'b0, lvAboveGood = 1'b0, hvInLimit = 1'b0, lvInLimit = 1'b0;
    logic hvFastTrip = 1'b0, lvFastTrip = 1'b0, hvOutBelowBleed = 1'b0, lvTimeout = 1'b0;
    logic hvSeriesEnhancedN = 1'b1, lvDirectionN = 1'b1, lvGateOnN = 1'b1;
    wire [7:0] regAddress, regWriteData, regReadData;
    wire       regWrite, regRead, regReadValid;
    wire       hvSeriesGate, oringBlockGate, hvOringPositiveOffset, hvDischargeConnect;
    wire [3:0] hvLimitScale;
    wire [1:0] hvGoodThresholdSel;
    logic [7:0] pat [3] = '{8'h5A, 8'hA5, 8'h00};
    logic [7:0] d;
    logic       ok;
    int         fails = 0, n_checks = 0;

    // 200 MHz clock
    initial forever #2.5 clock = ~clock;

    mgmt_host_model host_inst (.clock(clock), .regAddress(regAddress), .regWrite(regWrite),
        .regWriteData(regWriteData), .regRead(regRead), .regReadData(regReadData),
        .regReadValid(regReadValid));

    // Short fault unit keeps the trip scenarios to a few dozen cycles
    hot_swap_config_status_regs #(.UNIT_CYCLES(4)) hot_swap_config_status_regs_inst (
        .clock(clock), .resetn(resetn), .regAddress(regAddress), .regWrite(regWrite),
        .regWriteData(regWriteData), .regRead(regRead), .regReadData(regReadData),
        .regReadValid(regReadValid), .hvAboveGood(hvAboveGood), .lvAboveGood(lvAboveGood),
        .hvInLimit(hvInLimit), .lvInLimit(lvInLimit), .hvFastTrip(hvFastTrip),
        .lvFastTrip(lvFastTrip), .hvOutBelowBleed(hvOutBelowBleed), .lvTimeout(lvTimeout),
        .hvSeriesEnhancedN(hvSeriesEnhancedN), .lvDirectionN(lvDirectionN),
        .lvGateOnN(lvGateOnN), .hvSeriesGate(hvSeriesGate), .oringBlockGate(oringBlockGate),
        .hvLimitScale(hvLimitScale), .hvGoodThresholdSel(hvGoodThresholdSel),
        .hvOringPositiveOffset(hvOringPositiveOffset),
        .hvDischargeConnect(hvDischargeConnect));

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Read with answer bound; a lost answer ends the run
    task automatic rdck(input logic [7:0] a, input logic [7:0] exp);
        host_inst.rd(a, d, ok);
        if (ok !== 1'b1) begin
            fails++;
            stop_test();
        end
        check("read data", d, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic gate(input logic s, input logic b);
        check("series gate", {7'h0, hvSeriesGate}, {7'h0, s});
        check("block gate", {7'h0, oringBlockGate}, {7'h0, b});
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        stop_test();
    end

    initial begin
        cyc(3);
        resetn = 1'b1;
        cyc(1);
        // Reset values, read-only and unmapped places
        check("scale", {4'h0, hvLimitScale}, 8'h0F);
        rdck(8'h03, 8'hBF);
        rdck(8'h04, 8'h01);
        rdck(8'h07, 8'h00);
        host_inst.wr(8'h09, 8'hFF);
        rdck(8'h09, 8'hB0);
        rdck(8'h0A, 8'h00);
        // Trim fields follow the limits register, discharge follows the timing register
        foreach (pat[i]) begin
            host_inst.wr(8'h03, pat[i]);
            cyc(2);
            check("scale", {4'h0, hvLimitScale}, {4'h0, pat[i][3:0]});
            check("good sel", {6'h0, hvGoodThresholdSel}, {6'h0, pat[i][5:4]});
            check("offset", {7'h0, hvOringPositiveOffset}, {7'h0, pat[i][6]});
            rdck(8'h03, pat[i]);
        end
        host_inst.wr(8'h04, 8'h81);
        cyc(2);
        check("discharge", {7'h0, hvDischargeConnect}, 8'h01);
        host_inst.wr(8'h04, 8'h03);
        cyc(2);
        check("discharge", {7'h0, hvDischargeConnect}, 8'h00);
        // Enable with permit, then withdraw permit
        host_inst.wr(8'h03, 8'h8F);
        host_inst.wr(8'h04, 8'h23);
        cyc(2);
        gate(1'b1, 1'b1);
        rdck(8'h09, 8'hB8);
        host_inst.wr(8'h03, 8'h0F);
        cyc(2);
        gate(1'b1, 1'b0);
        rdck(8'h09, 8'hB0);
        // Limit shorter than the fault time must not trip
        hvInLimit = 1'b1;
        cyc(8);
        hvInLimit = 1'b0;
        cyc(4);
        gate(1'b1, 1'b0);
        rdck(8'h08, 8'h10);
        rdck(8'h08, 8'h00);
        // Shorter fault time once charged, then a sustained limit trips
        host_inst.wr(8'h04, 8'h21);
        hvInLimit = 1'b1;
        // Still on before one full fault unit of limit has run
        cyc(5);
        gate(1'b1, 1'b0);
        cyc(7);
        hvInLimit = 1'b0;
        gate(1'b0, 1'b0);
        rdck(8'h07, 8'h20);
        rdck(8'h07, 8'h00);
        // Re-arm lockout holds turn-on until the output bleeds down
        host_inst.wr(8'h04, 8'h01);
        host_inst.wr(8'h04, 8'h61);
        cyc(6);
        gate(1'b0, 1'b0);
        hvOutBelowBleed = 1'b1;
        cyc(6);
        gate(1'b1, 1'b0);
        host_inst.wr(8'h04, 8'h41);
        cyc(2);
        gate(1'b0, 1'b0);
        // Good-level falls and event rises latch their flags
        hvAboveGood = 1'b1;
        lvAboveGood = 1'b1;
        cyc(5);
        hvAboveGood = 1'b0;
        lvAboveGood = 1'b0;
        {lvTimeout, hvFastTrip, lvInLimit, lvFastTrip} = 4'hF;
        cyc(5);
        host_inst.rd(8'h07, d, ok);
        check("hv good loss", {7'h0, d[4]}, 8'h01);
        check("lv good loss", {7'h0, d[6]}, 8'h01);
        check("lv timeout", {7'h0, d[7]}, 8'h01);
        host_inst.rd(8'h08, d, ok);
        check("hv fast trip", {7'h0, d[5]}, 8'h01);
        check("lv overcurrent", {7'h0, d[6]}, 8'h01);
        check("lv fast trip", {7'h0, d[7]}, 8'h01);
        rdck(8'h08, 8'h00);
        // Live status follows its pins without latching
        {hvSeriesEnhancedN, lvDirectionN, lvGateOnN} = 3'h0;
        cyc(4);
        rdck(8'h09, 8'h00);
        stop_test();
    end
endmodule // tb_top
